/* pkg/fam_pkg.sv */
/*
 types shared by the address map block: op classes, erase sizes, states.
 assumes fam_regs.svh is on the include path.
*/
`include "fam_regs.svh"
package fam_pkg;
    typedef enum logic [2:0] {
        FAM_CL_REJ = 3'b000, FAM_CL_READ = 3'b001, FAM_CL_PROG = 3'b010,
        FAM_CL_ERASE = 3'b011, FAM_CL_DISC = 3'b100
    } fam_cls_e;
    typedef enum logic [1:0] {
        FAM_ES_SECT = 2'b00, FAM_ES_BLK = 2'b01, FAM_ES_CHIP = 2'b10,
        FAM_ES_SREG = 2'b11
    } fam_esize_e;
    typedef enum logic [1:0] {
        FAM_ST_IDLE = 2'b00, FAM_ST_RD = 2'b01, FAM_ST_GET = 2'b10
    } fam_state_e;
    // security register index sits just above the in-sector bits
    function automatic logic [1:0] fam_sr_idx(input logic [23:0] a);
        fam_sr_idx = a[`FAM_SR_IDX_LSB+1:`FAM_SR_IDX_LSB];
    endfunction
endpackage

/* pkg/fam_regs.svh */
/*
 constants of the flash address map and discovery space: widths, opcodes,
 address fields, discovery bytes. assumes it is included by bare name.
*/
// Contract
// - main array is 8 MiB, 2048 sectors of 4 KiB, 24-bit byte addresses
// - 64 KiB blocks hold sixteen sectors, block 0 starts at zero
// - array splits into 32768 pages of 256 bytes, each programmable alone
// - program only moves bits from 1 to 0; erase restores 1
// - erase by sector, block or whole chip; never by page
// - sectors span low twelve address bits 000h to fffh
// - four 256-byte security registers at n*1000h to n*1000h+0ffh
// - security registers 1 to 3 erase, program and lock on their own
// - a set lock bit blocks erase and program of that register forever; here only while its sec_lock input bit is held high
// - opcode 5ah reads discovery bytes from register 0, not the array
// - discovery space is read-only; program or erase there is ignored
// - header starts at 0000h; 0010h up to table start is undefined
// - table begins 0030h, content ends 006fh, 0070h to 00ffh reserved
// - discovery byte 00h reads 53h
// - space holds header then one basic parameter table it points to
// - discovery byte 04h reads minor revision 06h
// - discovery byte 05h reads major revision 01h
// - byte 06h reads 00h, byte 07h reads ffh
`ifndef FAM_REGS_SVH
`define FAM_REGS_SVH
`define FAM_ARRAY_MSB 23
`define FAM_SECTOR_LSB 12
`define FAM_BLOCK_LSB 16
`define FAM_PAGE_LSB 8
`define FAM_SR_IDX_LSB 12
`define FAM_OP_RD 8'h03
`define FAM_OP_PP 8'h02
`define FAM_OP_SE 8'h20
`define FAM_OP_BE 8'hd8
`define FAM_OP_CE 8'hc7
`define FAM_OP_SRRD 8'h48
`define FAM_OP_SRPP 8'h42
`define FAM_OP_SRSE 8'h44
`define FAM_OP_DISC 8'h5a
`define FAM_SIG0 8'h53
`define FAM_SIG1 8'h46
`define FAM_SIG2 8'h44
`define FAM_SIG3 8'h50
`define FAM_MINOR 8'h06
`define FAM_MAJOR 8'h01
`define FAM_NPH 8'h00
`define FAM_UNUSED 8'hff
`define FAM_PH_ID 8'h00
`define FAM_PH_LEN 8'h10
`define FAM_HDR_END 8'h0f
`define FAM_BPT_START 8'h30
`define FAM_BPT_END 8'h6f
`define FAM_BPT_FILL 8'hff
`define FAM_RSVD 8'hff
`define FAM_ERR_DATA 8'h00
`endif

/* verif/fam_store_model.sv */
/*
 storage model behind the address map block: byte store keyed by space
 and address, erased bytes read ff. assumes one clock shared with the block.
*/
`timescale 1ns/1ps
module fam_store_model (
    input wire logic clk_sys,
    input wire logic mem_space_ff,
    input wire logic [23:0] mem_addr_ff,
    input wire logic mem_rd_ff,
    input wire logic mem_wr_ff,
    input wire logic [7:0] mem_wdata_ff,
    input wire logic mem_erase_ff,
    input wire fam_pkg::fam_esize_e mem_esize_ff,
    output logic [7:0] mem_rdata
);
    import fam_pkg::*;
    logic [7:0] mem [logic [24:0]];
    logic [24:0] kill [$];
    initial mem_rdata = 8'h5a;
    // a byte absent from the store is erased; idle data toggles so no stale value passes
    always @(posedge clk_sys) begin
        if (mem_rd_ff) begin
            mem_rdata <= mem.exists({mem_space_ff, mem_addr_ff}) ?
                mem[{mem_space_ff, mem_addr_ff}] : 8'hff;
        end else begin
            mem_rdata <= ~mem_rdata;
        end
    end
    // byte writes and erase ranges; keys gathered first, deleting inside foreach is unsafe
    always @(posedge clk_sys) begin
        if (mem_wr_ff) begin
            mem[{mem_space_ff, mem_addr_ff}] = mem_wdata_ff;
        end
        if (mem_erase_ff) begin
            kill.delete();
            foreach (mem[k]) begin
                case (mem_esize_ff)
                    FAM_ES_SECT: if (!k[24] && k[23:12] == mem_addr_ff[23:12]) kill.push_back(k);
                    FAM_ES_BLK: if (!k[24] && k[23:16] == mem_addr_ff[23:16]) kill.push_back(k);
                    FAM_ES_CHIP: if (!k[24]) kill.push_back(k);
                    default: if (k[24] && k[13:12] == mem_addr_ff[13:12]) kill.push_back(k);
                endcase
            end
            foreach (kill[i]) begin
                mem.delete(kill[i]);
            end
        end
    end
endmodule // fam_store_model

/* verif/fam_top_tb.sv */
/*
 self-checking bench for the address map block with a storage model.
 assumes one 20 MHz clock; inputs change on falling edges.
*/
`timescale 1ns/1ps
module fam_top_tb;
    import fam_pkg::*;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic req_valid = 1'b0;
    logic [7:0] req_opcode = 8'h00;
    logic [23:0] req_addr = 24'h000000;
    logic [7:0] req_wdata = 8'h00;
    logic [3:1] sec_lock = 3'h0;
    logic [7:0] mem_rdata;
    logic req_ready_ff, rsp_valid_ff, rsp_err_ff, mem_space_ff;
    logic mem_rd_ff, mem_wr_ff, mem_erase_ff;
    logic [7:0] rsp_data_ff, mem_wdata_ff;
    logic [23:0] mem_addr_ff;
    fam_esize_e mem_esize_ff;
    int fail_count = 0;
    int check_count = 0;
    int cyc = 0;
    always #25 clk_sys = ~clk_sys;
    fam_top fam_top_inst (.clk_sys(clk_sys), .rst(rst), .req_valid(req_valid),
        .req_opcode(req_opcode), .req_addr(req_addr), .req_wdata(req_wdata),
        .sec_lock(sec_lock), .mem_rdata(mem_rdata), .req_ready_ff(req_ready_ff),
        .rsp_valid_ff(rsp_valid_ff), .rsp_data_ff(rsp_data_ff), .rsp_err_ff(rsp_err_ff),
        .mem_space_ff(mem_space_ff), .mem_addr_ff(mem_addr_ff), .mem_rd_ff(mem_rd_ff),
        .mem_wr_ff(mem_wr_ff), .mem_wdata_ff(mem_wdata_ff), .mem_erase_ff(mem_erase_ff),
        .mem_esize_ff(mem_esize_ff));
    fam_store_model fam_store_model_inst (.clk_sys(clk_sys), .mem_space_ff(mem_space_ff),
        .mem_addr_ff(mem_addr_ff), .mem_rd_ff(mem_rd_ff), .mem_wr_ff(mem_wr_ff),
        .mem_wdata_ff(mem_wdata_ff), .mem_erase_ff(mem_erase_ff),
        .mem_esize_ff(mem_esize_ff), .mem_rdata(mem_rdata));
    task automatic wrap_up();
        if (fail_count == 0 && check_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // whole run is under two hundred cycles; the ceiling leaves wide margin
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (cyc == 6000) begin
            fail_count++;
            wrap_up();
        end
    end
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        check_count++;
        if (g !== e) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask
    // one request: bounded wait for ready, hold valid for one clock edge, then a bounded wait for the answer
    task automatic xfer(input logic [7:0] op, input logic [23:0] a, input logic [7:0] wd,
        output logic [7:0] rd, output logic er);
        int n;
        n = 0;
        while (req_ready_ff !== 1'b1 && n < 20) begin
            @(negedge clk_sys);
            n++;
        end
        req_valid = 1'b1;
        req_opcode = op;
        req_addr = a;
        req_wdata = wd;
        @(posedge clk_sys);
        @(negedge clk_sys);
        req_valid = 1'b0;
        n = 0;
        while (rsp_valid_ff !== 1'b1 && n < 8) begin
            @(negedge clk_sys);
            n++;
        end
        chk("rsp_valid", 8'h01, {7'h00, rsp_valid_ff});
        chk("req_ready", 8'h01, {7'h00, req_ready_ff});
        rd = rsp_data_ff;
        er = rsp_err_ff;
        @(negedge clk_sys);
    endtask
    task automatic rd_ok(input logic [7:0] op, input logic [23:0] a, input logic [7:0] e);
        logic [7:0] d;
        logic er;
        xfer(op, a, 8'hff, d, er);
        chk("rsp_err", 8'h00, {7'h00, er});
        chk("rsp_data", e, d);
    endtask
    task automatic wr(input logic [7:0] op, input logic [23:0] a, input logic [7:0] wd);
        logic [7:0] d;
        logic er;
        xfer(op, a, wd, d, er);
        chk("rsp_err", 8'h00, {7'h00, er});
    endtask
    task automatic bad(input logic [7:0] op, input logic [23:0] a);
        logic [7:0] d;
        logic er;
        xfer(op, a, 8'h00, d, er);
        chk("rsp_err", 8'h01, {7'h00, er});
    endtask
    // discovery header, pointer, reserved bytes and address folding
    task automatic t_disc();
        logic [7:0] hdr [8];
        hdr = '{8'h53, 8'h46, 8'h44, 8'h50, 8'h06, 8'h01, 8'h00, 8'hff};
        wr(8'h02, 24'h000000, 8'h00);
        for (int i = 0; i < 8; i++) rd_ok(8'h5a, 24'(i), hdr[i]);
        rd_ok(8'h5a, 24'h00000c, 8'h30);
        rd_ok(8'h5a, 24'h000010, 8'hff);
        rd_ok(8'h5a, 24'h000070, 8'hff);
        rd_ok(8'h5a, 24'h0000ff, 8'hff);
        rd_ok(8'h5a, 24'h7fff00, 8'h53);
        rd_ok(8'h48, 24'h000004, 8'h06);
    endtask
    // program clears bits only; top of array, page neighbours, refusals
    task automatic t_main();
        wr(8'h02, 24'h7fffff, 8'h0f);
        wr(8'h02, 24'h7fffff, 8'hf0);
        rd_ok(8'h03, 24'h7fffff, 8'h00);
        wr(8'h02, 24'h7ffeff, 8'h3c);
        rd_ok(8'h03, 24'h7ffeff, 8'h3c);
        rd_ok(8'h03, 24'h7fff00, 8'hff);
        bad(8'h02, 24'h800000);
        bad(8'h00, 24'h000000);
    endtask
    // sector and block erase touch only their own range; chip erase clears the array
    task automatic t_erase();
        wr(8'h02, 24'h000fff, 8'h11);
        wr(8'h02, 24'h001000, 8'h22);
        wr(8'h20, 24'h001abc, 8'h00);
        rd_ok(8'h03, 24'h001000, 8'hff);
        rd_ok(8'h03, 24'h000fff, 8'h11);
        wr(8'h02, 24'h00f000, 8'h33);
        wr(8'h02, 24'h01ffff, 8'h44);
        wr(8'hd8, 24'h018000, 8'h00);
        rd_ok(8'h03, 24'h01ffff, 8'hff);
        rd_ok(8'h03, 24'h00f000, 8'h33);
        wr(8'hc7, 24'h000000, 8'h00);
        rd_ok(8'h03, 24'h00f000, 8'hff);
        rd_ok(8'h03, 24'h7fffff, 8'hff);
    endtask
    // security registers stand alone; locks and register 0 refuse changes
    task automatic t_sreg();
        wr(8'h42, 24'h0010aa, 8'h5c);
        rd_ok(8'h48, 24'h0010aa, 8'h5c);
        rd_ok(8'h48, 24'h0020aa, 8'hff);
        rd_ok(8'h03, 24'h0010aa, 8'hff);
        wr(8'h42, 24'h0030ff, 8'h81);
        wr(8'h44, 24'h001000, 8'h00);
        rd_ok(8'h48, 24'h0010aa, 8'hff);
        rd_ok(8'h48, 24'h0030ff, 8'h81);
        sec_lock = 3'b100;
        bad(8'h42, 24'h0030ff);
        bad(8'h44, 24'h003000);
        rd_ok(8'h48, 24'h0030ff, 8'h81);
        bad(8'h42, 24'h000010);
        bad(8'h44, 24'h000000);
        rd_ok(8'h5a, 24'h000010, 8'hff);
        rd_ok(8'h5a, 24'h000000, 8'h53);
    endtask
    initial begin
        repeat (8) @(negedge clk_sys);
        rst = 1'b0;
        @(negedge clk_sys);
        t_disc();
        t_main();
        t_erase();
        t_sreg();
        wrap_up();
    end
endmodule // fam_top_tb

/* verilog/fam_decode.sv */
/*
 combinational decode of opcode and address into op class, space,
 storage address and erase size. assumes inputs held while decoded.
*/
`timescale 1ns/1ps
`include "fam_regs.svh"
module fam_decode (
    input wire logic [7:0] opcode,
    input wire logic [23:0] addr,
    input wire logic [3:1] sec_lock,
    output fam_pkg::fam_cls_e cls,
    output logic space,
    output logic [23:0] maddr,
    output fam_pkg::fam_esize_e esize
);
    import fam_pkg::*;
    logic [1:0] idx;
    logic [3:0] locked;
    logic in_arr;
    assign idx = fam_sr_idx(addr);
    // register 0 reads as always locked so the discovery space stays put
    assign locked = {sec_lock, 1'b1};
    assign in_arr = ~addr[`FAM_ARRAY_MSB];
    // opcode decode; out-of-array or locked requests fall to reject
    always_comb begin
        cls = FAM_CL_REJ;
        space = 1'b0;
        maddr = addr;
        esize = FAM_ES_SECT;
        case (opcode)
            `FAM_OP_RD: if (in_arr) cls = FAM_CL_READ;
            `FAM_OP_PP: if (in_arr) cls = FAM_CL_PROG;
            `FAM_OP_SE: if (in_arr) begin
                cls = FAM_CL_ERASE;
                maddr = {addr[23:`FAM_SECTOR_LSB], 12'h000};
            end
            `FAM_OP_BE: if (in_arr) begin
                cls = FAM_CL_ERASE;
                esize = FAM_ES_BLK;
                maddr = {addr[23:`FAM_BLOCK_LSB], 16'h0000};
            end
            `FAM_OP_CE: begin
                cls = FAM_CL_ERASE;
                esize = FAM_ES_CHIP;
                maddr = 24'h000000;
            end
            `FAM_OP_SRRD: begin
                cls = (idx == 2'h0) ? FAM_CL_DISC : FAM_CL_READ;
                space = 1'b1;
                maddr = {10'h000, idx, 4'h0, addr[7:0]};
            end
            `FAM_OP_SRPP: if (!locked[idx]) begin
                cls = FAM_CL_PROG;
                space = 1'b1;
                maddr = {10'h000, idx, 4'h0, addr[7:0]};
            end
            `FAM_OP_SRSE: if (!locked[idx]) begin
                cls = FAM_CL_ERASE;
                space = 1'b1;
                esize = FAM_ES_SREG;
                maddr = {10'h000, idx, 12'h000};
            end
            `FAM_OP_DISC: cls = FAM_CL_DISC;
            default: cls = FAM_CL_REJ;
        endcase
    end
endmodule // fam_decode

/* verilog/fam_disc_rom.sv */
/*
 discovery space contents, one byte per low address. assumes the caller
 passes only the low eight address bits.
*/
`timescale 1ns/1ps
`include "fam_regs.svh"
module fam_disc_rom (
    input wire logic [7:0] baddr,
    output logic [7:0] bdata
);
    import fam_pkg::*;
    // header first, then the single table it points to
    always_comb begin
        case (baddr)
            8'h00: bdata = `FAM_SIG0;
            8'h01: bdata = `FAM_SIG1;
            8'h02: bdata = `FAM_SIG2;
            8'h03: bdata = `FAM_SIG3;
            8'h04: bdata = `FAM_MINOR;
            8'h05: bdata = `FAM_MAJOR;
            8'h06: bdata = `FAM_NPH;
            8'h07: bdata = `FAM_UNUSED;
            8'h08: bdata = `FAM_PH_ID;
            8'h09: bdata = `FAM_MINOR;
            8'h0a: bdata = `FAM_MAJOR;
            8'h0b: bdata = `FAM_PH_LEN; // table length in dwords
            8'h0c: bdata = `FAM_BPT_START; // pointer to the table
            8'h0d: bdata = 8'h00;
            8'h0e: bdata = 8'h00;
            8'h0f: bdata = `FAM_UNUSED;
            default: begin
                // table content reads as the fill byte ffh; reserved bytes stay fixed
                if (baddr >= `FAM_BPT_START && baddr <= `FAM_BPT_END)
                    bdata = `FAM_BPT_FILL;
                else
                    bdata = `FAM_RSVD;
            end
        endcase
    end
endmodule // fam_disc_rom

/* verilog/fam_top.sv */
/*
 address map controller: takes one byte request at a time, routes it to
 the main array, a security register or the discovery space, and drives
 the storage port. assumes storage answers a read one cycle after mem_rd
 and performs erases on its own from base and size.
*/
`timescale 1ns/1ps
`include "fam_regs.svh"
module fam_top (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic req_valid,
    input wire logic [7:0] req_opcode,
    input wire logic [23:0] req_addr,
    input wire logic [7:0] req_wdata,
    input wire logic [3:1] sec_lock,
    input wire logic [7:0] mem_rdata,
    output logic req_ready_ff,
    output logic rsp_valid_ff,
    output logic [7:0] rsp_data_ff,
    output logic rsp_err_ff,
    output logic mem_space_ff,
    output logic [23:0] mem_addr_ff,
    output logic mem_rd_ff,
    output logic mem_wr_ff,
    output logic [7:0] mem_wdata_ff,
    output logic mem_erase_ff,
    output fam_pkg::fam_esize_e mem_esize_ff
);
    import fam_pkg::*;

    fam_cls_e cls;
    fam_esize_e esize;
    fam_state_e state_ff;
    logic space;
    logic [23:0] maddr;
    logic [7:0] rom_data;
    logic acc;
    logic is_prog_ff;
    logic [7:0] new_ff;
    logic [7:0] old_ff;

    // a request is taken only while idle
    assign acc = req_valid & req_ready_ff;

    fam_decode u_dec (
        .opcode(req_opcode),
        .addr(req_addr),
        .sec_lock(sec_lock),
        .cls(cls),
        .space(space),
        .maddr(maddr),
        .esize(esize)
    );

    // only the low byte selects inside the discovery space
    fam_disc_rom u_rom (
        .baddr(req_addr[7:0]),
        .bdata(rom_data)
    );

    // sequencer: reads and programs need the old byte, the rest finish at once
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            state_ff <= FAM_ST_IDLE;
            req_ready_ff <= 1'b1;
        end else begin
            case (state_ff)
                FAM_ST_IDLE: begin
                    if (acc && (cls == FAM_CL_READ || cls == FAM_CL_PROG)) begin
                        state_ff <= FAM_ST_RD;
                        req_ready_ff <= 1'b0;
                    end
                end
                FAM_ST_RD: state_ff <= FAM_ST_GET;
                FAM_ST_GET: begin
                    state_ff <= FAM_ST_IDLE;
                    req_ready_ff <= 1'b1;
                end
                default: begin
                    state_ff <= FAM_ST_IDLE;
                    req_ready_ff <= 1'b1;
                end
            endcase
        end
    end

    // captured request; the address stays on the storage port till done
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            mem_space_ff <= 1'b0;
            mem_addr_ff <= 24'h000000;
            mem_esize_ff <= FAM_ES_SECT;
            is_prog_ff <= 1'b0;
            new_ff <= 8'h00;
        end else if (acc && cls != FAM_CL_REJ && cls != FAM_CL_DISC) begin
            mem_space_ff <= space;
            mem_addr_ff <= maddr;
            mem_esize_ff <= esize;
            is_prog_ff <= (cls == FAM_CL_PROG);
            new_ff <= req_wdata;
        end
    end

    // read strobe for both plain reads and the read half of a program
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            mem_rd_ff <= 1'b0;
        end else begin
            mem_rd_ff <= acc && (cls == FAM_CL_READ || cls == FAM_CL_PROG);
        end
    end

    // old byte, kept so the check can confirm the write only clears bits
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            old_ff <= 8'h00;
        end else if (state_ff == FAM_ST_GET) begin
            old_ff <= mem_rdata;
        end
    end

    // write: and of old and new, a bit at 0 never returns to 1 here
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            mem_wr_ff <= 1'b0;
            mem_wdata_ff <= 8'h00;
        end else begin
            mem_wr_ff <= (state_ff == FAM_ST_GET) && is_prog_ff;
            if (state_ff == FAM_ST_GET && is_prog_ff)
                mem_wdata_ff <= mem_rdata & new_ff;
        end
    end

    // erase pulse; storage fills the sized range with ones
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            mem_erase_ff <= 1'b0;
        end else begin
            mem_erase_ff <= acc && (cls == FAM_CL_ERASE);
        end
    end

    // answers: discovery and erase in one cycle, read and program in three
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            rsp_valid_ff <= 1'b0;
            rsp_data_ff <= 8'h00;
            rsp_err_ff <= 1'b0;
        end else begin
            rsp_valid_ff <= 1'b0;
            rsp_err_ff <= 1'b0;
            if (state_ff == FAM_ST_GET) begin
                rsp_valid_ff <= 1'b1;
                rsp_data_ff <= mem_rdata;
            end else if (acc && cls == FAM_CL_DISC) begin
                rsp_valid_ff <= 1'b1;
                rsp_data_ff <= rom_data;
            end else if (acc && cls == FAM_CL_ERASE) begin
                rsp_valid_ff <= 1'b1;
                rsp_data_ff <= `FAM_ERR_DATA;
            end else if (acc && cls == FAM_CL_REJ) begin
                // refused writes to locked or read-only space leave storage alone
                rsp_valid_ff <= 1'b1;
                rsp_err_ff <= 1'b1;
                rsp_data_ff <= `FAM_ERR_DATA;
            end
        end
    end

    // checks kept next to the logic they guard
    // lock view with register 0 always locked, as the decoder sees it
    logic [3:0] lock_map;
    assign lock_map = {sec_lock, 1'b1};
    sequence s_busy;
        !req_ready_ff [*2] ##1 req_ready_ff;
    endsequence
    sequence s_rd_acc;
        acc && (cls == FAM_CL_READ || cls == FAM_CL_PROG);
    endsequence
    sequence s_rd_done;
        mem_rd_ff ##1 !mem_rd_ff ##1 rsp_valid_ff;
    endsequence

    property p_read_flow;
        @(posedge clk_sys) disable iff (rst)
        s_rd_acc |=> s_rd_done;
    endproperty
    a_read_flow: assert property (p_read_flow)
        else $error("read or program did not answer in three cycles");

    property p_prog_clears;
        @(posedge clk_sys) disable iff (rst)
        mem_wr_ff |-> ((mem_wdata_ff & ~old_ff) == 8'h00);
    endproperty
    a_prog_clears: assert property (p_prog_clears)
        else $error("program raised a bit from 0 to 1");

    property p_sect_align;
        @(posedge clk_sys) disable iff (rst)
        mem_erase_ff && mem_esize_ff == FAM_ES_SECT |-> mem_addr_ff[11:0] == 12'h000;
    endproperty
    a_sect_align: assert property (p_sect_align)
        else $error("sector erase base not 4 KiB aligned");

    property p_blk_align;
        @(posedge clk_sys) disable iff (rst)
        mem_erase_ff && mem_esize_ff == FAM_ES_BLK |-> mem_addr_ff[15:0] == 16'h0000;
    endproperty
    a_blk_align: assert property (p_blk_align)
        else $error("block erase base not 64 KiB aligned");

    property p_sreg_erase;
        @(posedge clk_sys) disable iff (rst)
        mem_erase_ff && mem_esize_ff == FAM_ES_SREG |->
            mem_space_ff && mem_addr_ff[11:0] == 12'h000 && mem_addr_ff[13:12] != 2'h0;
    endproperty
    a_sreg_erase: assert property (p_sreg_erase)
        else $error("security register erase outside registers 1 to 3");

    property p_locked_safe;
        @(posedge clk_sys) disable iff (rst)
        acc && (req_opcode == `FAM_OP_SRPP || req_opcode == `FAM_OP_SRSE)
            && lock_map[fam_sr_idx(req_addr)]
        |=> (rsp_err_ff && !mem_rd_ff && !mem_erase_ff && !mem_wr_ff)
            ##1 (!mem_wr_ff [*2]);
    endproperty
    a_locked_safe: assert property (p_locked_safe)
        else $error("locked or discovery register was altered");

    property p_sig;
        @(posedge clk_sys) disable iff (rst)
        acc && req_opcode == `FAM_OP_DISC && req_addr[7:0] == 8'h00
        |=> rsp_valid_ff && rsp_data_ff == 8'h53;
    endproperty
    a_sig: assert property (p_sig)
        else $error("discovery byte 00h is not 53h");

    property p_rev;
        @(posedge clk_sys) disable iff (rst)
        acc && req_opcode == `FAM_OP_DISC && req_addr[7:1] == 7'h02
        |=> rsp_data_ff == ($past(req_addr[0]) ? `FAM_MAJOR : `FAM_MINOR) ##0 !mem_rd_ff;
    endproperty
    a_rev: assert property (p_rev)
        else $error("discovery revision bytes wrong");

    property p_disc_space;
        @(posedge clk_sys) disable iff (rst)
        acc && req_opcode == `FAM_OP_DISC
        |=> rsp_valid_ff && !mem_rd_ff ##1 (!rsp_valid_ff || $past(acc));
    endproperty
    a_disc_space: assert property (p_disc_space)
        else $error("discovery read touched the array or lingered");

    // no new request can slip in while a read or program is in flight
    property p_busy;
        @(posedge clk_sys) disable iff (rst)
        s_rd_acc |=> s_busy;
    endproperty
    a_busy: assert property (p_busy)
        else $error("ready did not drop for two cycles during read or program");

    property p_reject;
        @(posedge clk_sys) disable iff (rst)
        acc && cls == FAM_CL_REJ |=> rsp_valid_ff && rsp_err_ff && !mem_rd_ff && !mem_erase_ff;
    endproperty
    a_reject: assert property (p_reject)
        else $error("refused request did not answer with error or touched storage");

    property p_erase_ack;
        @(posedge clk_sys) disable iff (rst)
        acc && cls == FAM_CL_ERASE |=> mem_erase_ff && rsp_valid_ff && !rsp_err_ff;
    endproperty
    a_erase_ack: assert property (p_erase_ack)
        else $error("erase not strobed and answered in one cycle");

    property p_chip_main;
        @(posedge clk_sys) disable iff (rst)
        mem_erase_ff && mem_esize_ff == FAM_ES_CHIP |-> !mem_space_ff && mem_addr_ff == 24'h000000;
    endproperty
    a_chip_main: assert property (p_chip_main)
        else $error("chip erase not aimed at the main array from zero");

    // every erase base sits on a 4 KiB boundary, security registers included, so no base is page aligned only
    property p_no_page_erase;
        @(posedge clk_sys) disable iff (rst)
        mem_erase_ff |-> mem_addr_ff[11:0] == 12'h000;
    endproperty
    a_no_page_erase: assert property (p_no_page_erase)
        else $error("erase base finer than a sector");

    property p_arr_bound;
        @(posedge clk_sys) disable iff (rst)
        !mem_space_ff && (mem_rd_ff || mem_wr_ff) |-> !mem_addr_ff[`FAM_ARRAY_MSB];
    endproperty
    a_arr_bound: assert property (p_arr_bound)
        else $error("main array access beyond 8 MiB");

    property p_sreg_window;
        @(posedge clk_sys) disable iff (rst)
        mem_space_ff && (mem_rd_ff || mem_wr_ff)
        |-> mem_addr_ff[23:14] == 10'h000 && mem_addr_ff[11:8] == 4'h0;
    endproperty
    a_sreg_window: assert property (p_sreg_window)
        else $error("security register access outside its 256-byte window");

    // a write always follows its own read of the old byte by two cycles
    property p_wr_after_rd;
        @(posedge clk_sys) disable iff (rst)
        mem_wr_ff |-> $past(mem_rd_ff, 2);
    endproperty
    a_wr_after_rd: assert property (p_wr_after_rd)
        else $error("storage write without the read of the old byte");

    property p_disc_ro;
        @(posedge clk_sys) disable iff (rst)
        (mem_wr_ff || mem_erase_ff) && mem_space_ff |-> mem_addr_ff[13:12] != 2'h0;
    endproperty
    a_disc_ro: assert property (p_disc_ro)
        else $error("discovery register was written or erased");

    property p_hdr_count;
        @(posedge clk_sys) disable iff (rst)
        acc && req_opcode == `FAM_OP_DISC && req_addr[7:0] == 8'h06
        |=> rsp_valid_ff && rsp_data_ff == `FAM_NPH;
    endproperty
    a_hdr_count: assert property (p_hdr_count)
        else $error("discovery header count byte wrong");
endmodule // fam_top
